// File: hdl/pfp_debounce.sv
// Purpose: Continuous-assertion debounce of one indication
// Assumes: Input already synchronised to clk
// Notes: Done asserts once input held for LIMIT cycles
`timescale 1ns/1ps
module pfp_debounce #(
  parameter int LIMIT = 16,
  parameter int W = 26
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Indication in, debounced level out
  input wire logic level,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  localparam logic [W-1:0] LIM = W'(LIMIT);
  always_comb begin
    if (!level) begin
      nxt_cnt = '0; // R18
    end else if (cnt_ff < LIM) begin
      nxt_cnt = cnt_ff + W'(1);
    end else begin
      nxt_cnt = cnt_ff;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign done = (cnt_ff >= LIM);
endmodule // pfp_debounce

// File: hdl/pfp_fault_ctrl.sv
// Purpose: Fault detection and retry control for a port power switch
// Assumes: Comparator inputs asynchronous; attach detect is an input
// Notes: One clock, asynchronous active-high reset
//
// Functional notes
// [R1] Short to ground held over 250us opens the power switch
// [R2] Retry reclose every 2 s while short persists
// [R3] Switch restored 2 s after short removed; code restores at the end of the running 2 s retry wait instead
// [R4] Overvoltage held over 1 ms opens the power switch
// [R5] Retry every 2 s while overvoltage persists
// [R6] Shield comparator assertion is a shield fault event
// [R7] After 4us shield debounce, ground FET gate driven low
// [R8] Shield fault: reset attach, wait 4us, then gate low
// [R9] Ground FET back on only after shield input clears
// [R10] Shield clear: gate on now, attach held off 2 s more
// [R11] Forward overcurrent held 50 ms opens the switch
// [R12] After either current fault, wait 2 s before enabling
// [R13] Overtemperature held over 100us shuts down
// [R14] Leave thermal shutdown after 100us below low threshold
// [R15] Faults reset attach machine then 2 s retry wait
// [R16] Switch closes only with valid Rd on a channel
// [R17] Otherwise switch opens only on channel detach
// [R18] Debounce counters restart when indication drops early
// [R19] Counters run on the free clock, wide enough for 2 s
`timescale 1ns/1ps
module pfp_fault_ctrl
  import pfp_pkg::*;
#(
  parameter int SHORT_LIMIT = SHORT_CYC,
  parameter int OV_LIMIT = OV_CYC,
  parameter int OC_LIMIT = OC_CYC,
  parameter int THERM_LIMIT = THERM_CYC,
  parameter int SHIELD_LIMIT = SHIELD_CYC,
  parameter int GATE_LIMIT = GATE_CYC,
  parameter int RETRY_LIMIT = RETRY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Comparator indications
  input wire logic short_det,
  input wire logic overvoltage_det,
  input wire logic overcurrent_det,
  input wire logic overtemp_det,
  input wire logic temp_low_det,
  input wire logic shield_det,
  // Attach detection on each configuration channel
  input wire logic config_channel_a_rd,
  input wire logic config_channel_b_rd,
  // Outputs
  output logic switched_port_power,
  output logic ground_fet_gate,
  output logic attach_reset,
  output logic thermal_shutdown,
  output logic retry_active
);
  typedef enum logic [2:0] {
    ST_DETACHED, ST_ATTACHED, ST_GATE_WAIT, ST_SHIELD_OFF, ST_FAULT_OFF, ST_RETRY
  } pfp_state_e;

  localparam int SYNC_N = 6;
  logic [SYNC_N-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [SYNC_N-1:0] nxt_lvl;
  logic [SYNC_N-1:0] raw;
  assign raw = {config_channel_b_rd, config_channel_a_rd, shield_det,
                overcurrent_det, overvoltage_det, short_det};

  // Three-stage sync; change taken when stages two and three agree
  always_comb begin
    for (int i = 0; i < SYNC_N; i++) begin
      nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  logic t1_ff, t2_ff, t3_ff, thi_ff, tlo1_ff, tlo2_ff, tlo3_ff, tlo_ff;
  logic nxt_thi, nxt_tlo;
  always_comb begin
    nxt_thi = (t2_ff == t3_ff) ? t3_ff : thi_ff;
    nxt_tlo = (tlo2_ff == tlo3_ff) ? tlo3_ff : tlo_ff;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {t1_ff, t2_ff, t3_ff, thi_ff} <= '0;
      {tlo1_ff, tlo2_ff, tlo3_ff, tlo_ff} <= '0;
    end else begin
      {t1_ff, t2_ff, t3_ff, thi_ff} <= {overtemp_det, t1_ff, t2_ff, nxt_thi};
      {tlo1_ff, tlo2_ff, tlo3_ff, tlo_ff} <= {temp_low_det, tlo1_ff, tlo2_ff, nxt_tlo};
    end
  end

  logic short_hit, ov_hit, oc_hit, hot_hit, cool_hit, shield_hit;
  pfp_debounce #(.LIMIT(SHORT_LIMIT), .W(CNT_W)) u_short ( // R1
    .clk(clk), .rst(rst), .level(lvl_ff[0]), .done(short_hit));
  pfp_debounce #(.LIMIT(OV_LIMIT), .W(CNT_W)) u_ov ( // R4
    .clk(clk), .rst(rst), .level(lvl_ff[1]), .done(ov_hit));
  pfp_debounce #(.LIMIT(OC_LIMIT), .W(CNT_W)) u_oc ( // R11
    .clk(clk), .rst(rst), .level(lvl_ff[2]), .done(oc_hit));
  pfp_debounce #(.LIMIT(SHIELD_LIMIT), .W(CNT_W)) u_shield ( // R6
    .clk(clk), .rst(rst), .level(lvl_ff[3]), .done(shield_hit));
  pfp_debounce #(.LIMIT(THERM_LIMIT), .W(CNT_W)) u_hot ( // R13
    .clk(clk), .rst(rst), .level(thi_ff), .done(hot_hit));
  pfp_debounce #(.LIMIT(THERM_LIMIT), .W(CNT_W)) u_cool ( // R14
    .clk(clk), .rst(rst), .level(tlo_ff), .done(cool_hit));

  // Thermal shutdown latch
  logic therm_ff, nxt_therm;
  always_comb begin
    nxt_therm = therm_ff;
    if (hot_hit) begin
      nxt_therm = 1'b1; // R13
    end else if (therm_ff && cool_hit) begin
      nxt_therm = 1'b0; // R14
    end
  end

  logic rd_valid, power_fault, fault_present;
  assign rd_valid = lvl_ff[4] | lvl_ff[5];
  assign power_fault = short_hit | ov_hit | oc_hit | hot_hit | therm_ff; // R13
  assign fault_present = lvl_ff[0] | lvl_ff[1] | lvl_ff[2] | therm_ff;

  pfp_state_e st_ff, nxt_st;
  logic [CNT_W-1:0] tmr_ff, nxt_tmr;
  localparam logic [CNT_W-1:0] RETRY_END = CNT_W'(RETRY_LIMIT - 1); // R19
  localparam logic [CNT_W-1:0] GATE_END = CNT_W'(GATE_LIMIT - 1);

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff + CNT_W'(1);
    unique case (st_ff)
      ST_DETACHED: begin
        nxt_tmr = '0;
        if (shield_hit) begin
          nxt_st = ST_GATE_WAIT;
        end else if (power_fault) begin
          nxt_st = ST_FAULT_OFF;
        end else if (rd_valid) begin
          nxt_st = ST_ATTACHED; // R16
        end
      end
      ST_ATTACHED: begin
        nxt_tmr = '0;
        if (shield_hit) begin
          nxt_st = ST_GATE_WAIT; // R8
        end else if (power_fault) begin
          nxt_st = ST_FAULT_OFF; // R15
        end else if (!rd_valid) begin
          nxt_st = ST_DETACHED; // R17
        end
      end
      ST_GATE_WAIT: begin
        if (tmr_ff >= GATE_END) begin
          nxt_st = ST_SHIELD_OFF; // R7 R8
          nxt_tmr = '0;
        end
      end
      ST_SHIELD_OFF: begin
        nxt_tmr = '0;
        if (!lvl_ff[3]) begin
          nxt_st = ST_RETRY; // R9 R10
        end
      end
      ST_FAULT_OFF: begin
        // Retry wait, then attempt reclose
        if (shield_hit) begin
          nxt_st = ST_GATE_WAIT;
          nxt_tmr = '0;
        end else if (tmr_ff >= RETRY_END) begin
          nxt_tmr = '0;
          nxt_st = fault_present ? ST_FAULT_OFF : ST_DETACHED; // R2 R5 R12
        end
      end
      ST_RETRY: begin
        if (shield_hit) begin
          nxt_st = ST_GATE_WAIT;
          nxt_tmr = '0;
        end else if (fault_present) begin
          nxt_st = ST_FAULT_OFF;
          nxt_tmr = '0;
        end else if (tmr_ff >= RETRY_END) begin
          nxt_st = ST_DETACHED; // R10
          nxt_tmr = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_DETACHED;
      tmr_ff <= '0;
      therm_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      therm_ff <= nxt_therm;
    end
  end

  // Registered outputs
  logic pwr_ff, gate_ff, arst_ff, retry_ff;
  logic nxt_pwr, nxt_gate, nxt_arst, nxt_retry;
  always_comb begin
    nxt_pwr = (nxt_st == ST_ATTACHED); // R1 R4 R11 R16 R17
    nxt_gate = (nxt_st != ST_SHIELD_OFF); // R7 R9
    nxt_arst = (nxt_st != ST_ATTACHED) && (nxt_st != ST_DETACHED);
    nxt_retry = (nxt_st == ST_FAULT_OFF) || (nxt_st == ST_RETRY);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_ff <= 1'b0;
      gate_ff <= 1'b1;
      arst_ff <= 1'b0;
      retry_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      gate_ff <= nxt_gate;
      arst_ff <= nxt_arst;
      retry_ff <= nxt_retry;
    end
  end
  assign switched_port_power = pwr_ff;
  assign ground_fet_gate = gate_ff;
  assign attach_reset = arst_ff;
  assign thermal_shutdown = therm_ff;
  assign retry_active = retry_ff;
endmodule // pfp_fault_ctrl

// File: hdl/pfp_pkg.sv
// Purpose: Constants for the port fault protection logic
// Assumes: 20 MHz system clock
// Notes: Times kept in their own units, cycle counts derived
package pfp_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  // Debounce and retry times
  localparam int SHORT_DEBOUNCE_US = 250;
  localparam int OVERVOLTAGE_DEBOUNCE_MS = 1;
  localparam int OVERCURRENT_DEBOUNCE_MS = 50;
  localparam int THERMAL_DEBOUNCE_US = 100;
  localparam int SHIELD_DEBOUNCE_US = 4;
  localparam int SHIELD_GATE_DELAY_US = 4;
  localparam int RETRY_INTERVAL_S = 2;
  // Derived cycle counts
  localparam int SHORT_CYC = SHORT_DEBOUNCE_US * 1000 / CLK_NS;
  localparam int OV_CYC = OVERVOLTAGE_DEBOUNCE_MS * 1000000 / CLK_NS;
  localparam int OC_CYC = OVERCURRENT_DEBOUNCE_MS * 1000 * (CLK_HZ / 1000000);
  localparam int THERM_CYC = THERMAL_DEBOUNCE_US * 1000 / CLK_NS;
  localparam int SHIELD_CYC = SHIELD_DEBOUNCE_US * 1000 / CLK_NS;
  localparam int GATE_CYC = SHIELD_GATE_DELAY_US * 1000 / CLK_NS;
  localparam int RETRY_CYC = RETRY_INTERVAL_S * CLK_HZ;
  localparam int CNT_W = 26;
endpackage

// File: test/pfp_fault_ctrl_assertions.sv
// Purpose: Port checks for fault control
// Assumes: Synchroniser adds about 4 cycles
// Notes: Bound to pfp_fault_ctrl
`timescale 1ns/1ps
module pfp_fault_ctrl_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Indications
  input wire logic short_det,
  input wire logic overvoltage_det,
  input wire logic overcurrent_det,
  input wire logic overtemp_det,
  input wire logic temp_low_det,
  input wire logic shield_det,
  input wire logic config_channel_a_rd,
  input wire logic config_channel_b_rd,
  // Outputs
  input wire logic switched_port_power,
  input wire logic ground_fet_gate,
  input wire logic attach_reset,
  input wire logic thermal_shutdown,
  input wire logic retry_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_power_needs_ok: assert property ($rose(switched_port_power) |->
    $past(config_channel_a_rd | config_channel_b_rd, 4) ||
    $past(config_channel_a_rd | config_channel_b_rd, 5))
    else $error("power closed without Rd");
  a_fault_opens_switch: assert property ($rose(attach_reset) |-> !switched_port_power)
    else $error("attach reset with power on");
  a_gate_after_reset: assert property ($fell(ground_fet_gate) |-> $past(attach_reset, 60))
    else $error("gate off too soon");
  a_retry_no_power: assert property (retry_active |-> !switched_port_power)
    else $error("power on during retry");
  a_thermal_no_power: assert property (thermal_shutdown |-> !switched_port_power)
    else $error("power on in shutdown");
  a_gate_back_clear: assert property ($rose(ground_fet_gate) |-> !$past(shield_det, 2))
    else $error("gate on with shield high");
  a_retry_has_cause: assert property ($rose(retry_active) |-> $rose(ground_fet_gate) ||
    $past(short_det | overvoltage_det | overcurrent_det | overtemp_det, 6))
    else $error("retry without held fault");
  a_drop_has_cause: assert property ($fell(switched_port_power) |-> attach_reset ||
    thermal_shutdown || !$past(config_channel_a_rd, 4) && !$past(config_channel_b_rd, 4))
    else $error("power dropped without cause");
  a_shield_hold: assert property ($rose(ground_fet_gate) |-> attach_reset[*8])
    else $error("attach freed with gate");
  c_retry: cover property ($rose(retry_active));
  c_gate: cover property ($fell(ground_fet_gate));
  c_thermal: cover property ($rose(thermal_shutdown));
endmodule // pfp_fault_ctrl_assertions

bind pfp_fault_ctrl pfp_fault_ctrl_assertions chk_i (.clk(clk), .rst(rst),
  .short_det(short_det), .overvoltage_det(overvoltage_det), .overcurrent_det(overcurrent_det),
  .overtemp_det(overtemp_det), .temp_low_det(temp_low_det), .shield_det(shield_det),
  .config_channel_a_rd(config_channel_a_rd), .config_channel_b_rd(config_channel_b_rd),
  .switched_port_power(switched_port_power), .ground_fet_gate(ground_fet_gate),
  .attach_reset(attach_reset), .thermal_shutdown(thermal_shutdown),
  .retry_active(retry_active));

// File: test/pfp_fault_ctrl_tb_top.sv
// Purpose: Scenario bench for fault control
// Assumes: Shortened limits, retry 200 cycles
// Notes: Outputs gathered in one vector
`timescale 1ns/1ps
module pfp_fault_ctrl_tb_top;
  logic clk = 0, rst = 1, shield = 0, tlow = 0, att = 0, side = 0, slow = 0;
  logic [3:0] flt = 4'h0;
  wire logic rd_a, rd_b;
  wire logic [4:0] o;
  int num_errors = 0, check_count = 0, cyc = 0;
  int lims[4] = '{20, 30, 50, 20};
  initial forever #25 clk = ~clk;
  pfp_port_model pm (.clk(clk), .attached(att), .flip(side), .slow(slow), .rd_a(rd_a),
    .rd_b(rd_b));
  pfp_fault_ctrl #(.SHORT_LIMIT(20), .OV_LIMIT(30), .OC_LIMIT(50), .THERM_LIMIT(20),
    .RETRY_LIMIT(200)) dut (.clk(clk), .rst(rst), .short_det(flt[0]),
    .overvoltage_det(flt[1]), .overcurrent_det(flt[2]), .overtemp_det(flt[3]),
    .temp_low_det(tlow), .shield_det(shield), .config_channel_a_rd(rd_a),
    .config_channel_b_rd(rd_b), .switched_port_power(o[0]), .ground_fet_gate(o[1]),
    .attach_reset(o[2]), .thermal_shutdown(o[3]), .retry_active(o[4]));
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wt(input string n, input int s, input logic v, input int lim);
    int i;
    i = 0;
    while (o[s] !== v && i < lim) begin
      go(1);
      i++;
    end
    chk(n, o[s], v);
  endtask
  task automatic t_attach(input logic f, input logic s);
    @(posedge clk) {side, slow, att} <= {f, s, 1'b1};
    wt("power on", 0, 1, 80);
  endtask
  task automatic t_fault(input int k, input int lim);
    @(posedge clk) flt[k] <= 1'b1;
    repeat (lim - 8) @(posedge clk);
    flt[k] <= 1'b0;
    go(10);
    chk("glitch", o[0], 1);
    @(posedge clk) flt[k] <= 1'b1;
    wt("trip", 0, 0, lim + 12);
    chk("attach reset", o[2], 1);
    chk("retry on", o[4], 1);
    chk("shutdown", o[3], k == 3);
    go(250);
    chk("still off", o[0], 0);
    @(posedge clk) {tlow, flt[k]} <= {k == 3, 1'b0};
    go(100);
    chk("retry wait", o[0], 0);
    wt("recover", 0, 1, 500);
    chk("retry off", o[4], 0);
    chk("shutdown clear", o[3], 0);
    @(posedge clk) tlow <= 1'b0;
  endtask
  task automatic t_shield;
    @(posedge clk) shield <= 1'b1;
    wt("gate off", 1, 0, 200);
    chk("shield power", o[0], 0);
    chk("shield reset", o[2], 1);
    @(posedge clk) shield <= 1'b0;
    wt("gate on", 1, 1, 12);
    go(150);
    chk("held", o[2], 1);
    chk("shield wait", o[4], 1);
    wt("reattach", 0, 1, 200);
  endtask
  task automatic t_detach;
    @(posedge clk) att <= 1'b0;
    wt("detach", 0, 0, 20);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk("reset", o, 5'h02);
    @(posedge clk) rst <= 1'b0;
    t_attach(0, 0);
    foreach (lims[k]) t_fault(k, lims[k]);
    t_shield();
    t_detach();
    t_attach(1, 1);
    t_detach();
    wrap_up();
  end
endmodule // pfp_fault_ctrl_tb_top

// File: test/pfp_port_model.sv
// Purpose: Attached port device presenting Rd
// Assumes: One clock
// Notes: Slow mode delays Rd by 40 cycles
`timescale 1ns/1ps
module pfp_port_model (
  // Clock
  input wire logic clk,
  // Controls
  input wire logic attached,
  input wire logic flip,
  input wire logic slow,
  // Rd on each channel
  output logic rd_a,
  output logic rd_b
);
  int dly = 0;
  always @(posedge clk) dly <= attached ? dly + 1 : 0;
  wire logic on = attached && dly >= (slow ? 40 : 2);
  assign rd_a = on && !flip;
  assign rd_b = on && flip;
endmodule // pfp_port_model
